// [pbc_basic_control.sv]
`timescale 1ns/1ps
module pbc_basic_control #(
   parameter int NUM_REGS = 32,
   parameter int RESET_CYCLES = pbc_pkg::SW_RESET_CYCLES
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Strap level, held by the board
   input wire logic strap_autoneg_and_speed,
   // Register access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [pbc_pkg::REG_ADDR_W-1:0] reg_addr,
   input wire logic [pbc_pkg::DATA_W-1:0] reg_wdata,
   output logic [pbc_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // Effective modes to the PHY core
   output logic chip_reset,
   output logic loopback,
   output logic speed_100,
   output logic full_duplex,
   output logic autoneg_en,
   output logic autoneg_restart,
   output logic power_down,
   output logic isolate,
   output logic col_test
);
   import pbc_pkg::*;

   typedef enum logic [1:0] {PBC_ST_IDLE, PBC_ST_RESET, PBC_ST_LATCH} pbc_state_t;

   // Parameters the logic cannot serve are refused while the design is built
   generate
      if (NUM_REGS != 32)
      begin : g_bad_num_regs
         $error("pbc_basic_control: NUM_REGS must be 32");
      end
      if (RESET_CYCLES < 1 || RESET_CYCLES > 255)
      begin : g_bad_reset_cycles
         $error("pbc_basic_control: RESET_CYCLES out of range");
      end
   endgenerate

   // Control fields
   logic ctl_loopback, ctl_speed, ctl_an_en, ctl_pdown, ctl_isolate, ctl_duplex, ctl_col;
   logic next_loopback, next_speed, next_an_en, next_pdown, next_isolate, next_duplex, next_col;
   logic sw_reset_bit, next_sw_reset_bit;
   logic an_restart_bit, next_an_restart_bit;
   pbc_state_t state, next_state;
   logic [7:0] rst_cnt, next_rst_cnt;
   logic strap_valid, next_strap_valid;
   // Outputs
   logic [DATA_W-1:0] next_rdata;
   logic next_rvalid, next_chip_reset, next_an_pulse;
   logic soft_rst;
   logic ctl_wr;
   logic wr_ok, sw_req;
   logic next_out_loopback, next_out_speed, next_out_duplex, next_out_an_en;
   logic next_out_pdown, next_out_isolate, next_out_col;
   logic [DATA_W-1:0] ctl_word;
   logic [DATA_W-1:0] gen_val [1:NUM_REGS-1];

   assign soft_rst = (state == PBC_ST_RESET);
   assign ctl_wr = reg_wr && (reg_addr == BASIC_CONTROL_ADDR);
   // Control writes are dropped until the straps are in, so a late strap never overwrites a manager's value
   assign wr_ok = ctl_wr && (state == PBC_ST_IDLE) && strap_valid;
   assign sw_req = wr_ok && reg_wdata[SW_RESET_BIT];

   // Other 31 words, standard and vendor alike
   genvar gi;
   generate
      for (gi = 1; gi < NUM_REGS; gi++)
      begin : g_reg
         pbc_gen_reg #(.WIDTH(DATA_W)) u_reg (
            .clk(clk),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .soft_rst(soft_rst),
            .wr_en(reg_wr && (reg_addr == REG_ADDR_W'(gi))),
            .wr_data(reg_wdata),
            .value(gen_val[gi])
         );
      end
   endgenerate

   always_comb
   begin
      ctl_word = '0;
      ctl_word[SW_RESET_BIT] = sw_reset_bit;
      ctl_word[LOOPBACK_BIT] = ctl_loopback;
      ctl_word[SPEED_BIT] = ctl_speed;
      ctl_word[AUTONEG_EN_BIT] = ctl_an_en;
      ctl_word[POWER_DOWN_BIT] = ctl_pdown;
      ctl_word[ISOLATE_BIT] = ctl_isolate;
      ctl_word[AN_RESTART_BIT] = an_restart_bit;
      ctl_word[DUPLEX_BIT] = ctl_duplex;
      ctl_word[COL_TEST_BIT] = ctl_col;
   end

   // Control register fields and the self-clearing restart bit
   always_comb
   begin
      next_loopback = ctl_loopback;
      next_speed = ctl_speed;
      next_an_en = ctl_an_en;
      next_pdown = ctl_pdown;
      next_isolate = ctl_isolate;
      next_duplex = ctl_duplex;
      next_col = ctl_col;
      next_an_restart_bit = 1'b0;
      next_an_pulse = 1'b0;
      case (state)
         PBC_ST_IDLE:
         begin
            if (wr_ok)
            begin
               next_loopback = reg_wdata[LOOPBACK_BIT];
               next_speed = reg_wdata[SPEED_BIT];
               next_an_en = reg_wdata[AUTONEG_EN_BIT];
               next_pdown = reg_wdata[POWER_DOWN_BIT];
               next_isolate = reg_wdata[ISOLATE_BIT];
               next_duplex = reg_wdata[DUPLEX_BIT];
               next_col = reg_wdata[COL_TEST_BIT];
               if (reg_wdata[AN_RESTART_BIT])
               begin
                  next_an_restart_bit = 1'b1;
                  next_an_pulse = 1'b1;
               end
               // First reset write out of power-down only wakes the chip
               if (sw_req && ctl_pdown)
                  next_pdown = 1'b0;
            end
         end
         PBC_ST_RESET:
         begin
            next_loopback = RST_LOOPBACK;
            next_pdown = RST_POWER_DOWN;
            next_isolate = RST_ISOLATE;
            next_duplex = RST_DUPLEX;
            next_col = RST_COL_TEST;
         end
         PBC_ST_LATCH:
         begin
            next_speed = strap_autoneg_and_speed;
            next_an_en = strap_autoneg_and_speed;
         end
         default:
            next_an_pulse = 1'b0;
      endcase
   end

   // Software reset sequencer; straps are caught after the release, never under the asynchronous reset
   always_comb
   begin
      next_state = state;
      next_rst_cnt = rst_cnt;
      next_strap_valid = strap_valid;
      next_sw_reset_bit = sw_reset_bit;
      next_chip_reset = 1'b0;
      case (state)
         PBC_ST_IDLE:
         begin
            if (!strap_valid)
               next_state = PBC_ST_LATCH;
            else if (sw_req && !ctl_pdown)
            begin
               next_sw_reset_bit = 1'b1;
               next_state = PBC_ST_RESET;
               next_rst_cnt = 8'(RESET_CYCLES);
            end
         end
         PBC_ST_RESET:
         begin
            next_chip_reset = 1'b1;
            if (rst_cnt <= 8'h01)
               next_state = PBC_ST_LATCH;
            else
               next_rst_cnt = rst_cnt - 8'h01;
         end
         PBC_ST_LATCH:
         begin
            next_strap_valid = 1'b1;
            next_sw_reset_bit = 1'b0;
            next_state = PBC_ST_IDLE;
         end
         default:
            next_state = PBC_ST_IDLE;
      endcase
   end

   // Read path; a read the same cycle as a write returns the old value
   always_comb
   begin
      next_rvalid = reg_rd;
      next_rdata = reg_rdata;
      if (reg_rd)
      begin
         if (reg_addr == BASIC_CONTROL_ADDR)
            next_rdata = ctl_word & ~RESERVED_MASK;
         else
            next_rdata = gen_val[reg_addr];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl_loopback <= RST_LOOPBACK;
         ctl_speed <= 1'b0;
         ctl_an_en <= 1'b0;
         ctl_pdown <= RST_POWER_DOWN;
         ctl_isolate <= RST_ISOLATE;
         ctl_duplex <= RST_DUPLEX;
         ctl_col <= RST_COL_TEST;
         an_restart_bit <= 1'b0;
         autoneg_restart <= 1'b0;
      end
      else if (clk_en)
      begin
         ctl_loopback <= next_loopback;
         ctl_speed <= next_speed;
         ctl_an_en <= next_an_en;
         ctl_pdown <= next_pdown;
         ctl_isolate <= next_isolate;
         ctl_duplex <= next_duplex;
         ctl_col <= next_col;
         an_restart_bit <= next_an_restart_bit;
         autoneg_restart <= next_an_pulse;
      end
   end

   // Sequencer state
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= PBC_ST_IDLE;
         rst_cnt <= 8'h00;
         strap_valid <= 1'b0;
         sw_reset_bit <= 1'b0;
         chip_reset <= 1'b0;
      end
      else if (clk_en)
      begin
         state <= next_state;
         rst_cnt <= next_rst_cnt;
         strap_valid <= next_strap_valid;
         sw_reset_bit <= next_sw_reset_bit;
         chip_reset <= next_chip_reset;
      end
   end

   // Read port
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end
      else if (clk_en)
      begin
         reg_rdata <= next_rdata;
         reg_rvalid <= next_rvalid;
      end
   end

   // Mode outputs, registered; the negotiated result lives in the core, so with
   // auto-negotiation on the manual speed and duplex are reported as don't-care zero
   always_comb
   begin
      next_out_loopback = next_loopback;
      next_out_speed = next_speed & ~next_an_en;
      next_out_duplex = next_duplex & ~next_an_en;
      next_out_an_en = next_an_en;
      next_out_pdown = next_pdown;
      next_out_isolate = next_isolate;
      next_out_col = next_col;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         loopback <= 1'b0;
         speed_100 <= 1'b0;
         full_duplex <= 1'b0;
         autoneg_en <= 1'b0;
         power_down <= 1'b0;
         isolate <= 1'b0;
         col_test <= 1'b0;
      end
      else if (clk_en)
      begin
         loopback <= next_out_loopback;
         speed_100 <= next_out_speed;
         full_duplex <= next_out_duplex;
         autoneg_en <= next_out_an_en;
         power_down <= next_out_pdown;
         isolate <= next_out_isolate;
         col_test <= next_out_col;
      end
   end
endmodule

// [pbc_pkg.sv]
// Functional notes
// - The device decodes 32 management registers, each reachable for read and write over the management interface.
// - Addresses 0h to Fh are the standard registers and 10h to 1Fh are vendor registers.
// - Writing 1 to bit 15 starts a software reset, the bit then clears itself, and it resets to 0.
// - Bit 14 selects loopback when 1, is read/write and resets to 0.
// - Bit 13 selects 100 Mbit/s when 1 and 10 Mbit/s when 0, and is ignored while auto-negotiation is on.
// - Bit 12 enables auto-negotiation, whose result then overrides the speed and duplex bits.
// - The reset values of speed select and auto-negotiation enable come from the latched strap level.
// - Bit 11 selects power-down when 1, is read/write and resets to 0.
// - Leaving power-down by software reset takes two writes: the first clears power-down, the second resets and re-latches straps.
// - Bit 10 isolates the PHY from its RMII data interface when 1 and resets to 0.
// - Writing 1 to bit 9 restarts auto-negotiation, the bit then clears itself, and it resets to 0.
// - Bit 8 selects full duplex when 1, is read/write and resets to 1.
// - Bit 7 enables the collision test when 1, is read/write and resets to 0.
package pbc_pkg;
   localparam int REG_ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam logic [4:0] BASIC_CONTROL_ADDR = 5'h00;
   localparam logic [4:0] VENDOR_BASE_ADDR = 5'h10;
   localparam int SW_RESET_BIT = 15;
   localparam int LOOPBACK_BIT = 14;
   localparam int SPEED_BIT = 13;
   localparam int AUTONEG_EN_BIT = 12;
   localparam int POWER_DOWN_BIT = 11;
   localparam int ISOLATE_BIT = 10;
   localparam int AN_RESTART_BIT = 9;
   localparam int DUPLEX_BIT = 8;
   localparam int COL_TEST_BIT = 7;
   localparam logic RST_LOOPBACK = 1'b0;
   localparam logic RST_POWER_DOWN = 1'b0;
   localparam logic RST_ISOLATE = 1'b0;
   localparam logic RST_DUPLEX = 1'b1;
   localparam logic RST_COL_TEST = 1'b0;
   localparam logic [15:0] RESERVED_MASK = 16'h007F;
   // Internal reset pulse length after software reset
   localparam int SW_RESET_NS = 40;
   localparam int CLK_NS = 4;
   localparam int SW_RESET_CYCLES = (SW_RESET_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [pbc_gen_reg.sv]
`timescale 1ns/1ps
// Generic register file word for the addresses outside basic control
module pbc_gen_reg #(
   parameter int WIDTH = 16
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic soft_rst,
   // Write
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   // Read
   output logic [WIDTH-1:0] value
);
   logic [WIDTH-1:0] next_value;

   always_comb
   begin
      next_value = value;
      if (soft_rst)
         next_value = '0;
      else if (wr_en)
         next_value = wr_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         value <= '0;
      else if (clk_en)
         value <= next_value;
   end
endmodule

// [pbc_basic_control_asserts.sv]
`timescale 1ns/1ps
module pbc_chk #(
   parameter int NUM_REGS = 32,
   parameter int RESET_CYCLES = 10
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   // Modes
   input wire logic chip_reset,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic autoneg_en,
   input wire logic autoneg_restart,
   input wire logic power_down
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   wire w0 = clk_en && reg_wr && reg_addr == 5'h00 && !chip_reset;
   // Counts the high cycles of an internal reset run
   always_comb next_cnt = chip_reset ? cnt + 8'h01 : 8'h00;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= 8'h00;
      else if (clk_en)
         cnt <= next_cnt;
   end
   a_read_answer: assert property (clk_en && reg_rd |=> reg_rvalid)
      else $error("read not answered");
   a_no_spurious: assert property (!(clk_en && reg_rd) |=> !reg_rvalid)
      else $error("answer without read");
   a_restart_pulse: assert property (w0 && reg_wdata[9] |=> autoneg_restart ##1 !autoneg_restart)
      else $error("restart pulse wrong");
   a_manual_masked: assert property (autoneg_en |-> !speed_100 && !full_duplex)
      else $error("manual mode leaks");
   a_rsvd_zero: assert property (reg_rvalid && $past(reg_addr) == 5'h00 |-> reg_rdata[6:0] == 7'h00)
      else $error("reserved bits set");
   a_reset_start: assert property (w0 && reg_wdata[15] && !power_down |-> ##2 chip_reset)
      else $error("reset not started");
   a_pd_exit: assert property (w0 && reg_wdata[15] && power_down |-> ##2 !power_down && !chip_reset)
      else $error("power-down exit wrong");
   a_reset_len: assert property ($fell(chip_reset) |-> cnt == RESET_CYCLES)
      else $error("reset length wrong");
   c_reset: cover property ($rose(chip_reset));
   c_restart: cover property (autoneg_restart);
   c_pd_exit: cover property (power_down ##1 !power_down);
endmodule
bind pbc_basic_control pbc_chk #(.NUM_REGS(NUM_REGS), .RESET_CYCLES(RESET_CYCLES)) u_chk (
   .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chip_reset(chip_reset),
   .speed_100(speed_100), .full_duplex(full_duplex), .autoneg_en(autoneg_en),
   .autoneg_restart(autoneg_restart), .power_down(power_down));

// [pbc_mgr.sv]
`timescale 1ns/1ps
module pbc_mgr (
   // Clock
   input wire logic clk,
   // Access
   output logic reg_wr,
   output logic reg_rd,
   output logic [4:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 16'h0000;
   end
   // Idle lines toggle so stale values are never mistaken for live ones
   task automatic idle;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      idle();
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
      idle();
   endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   logic clk = 0, rst_n = 0, clk_en = 1, strap = 1;
   logic reg_wr, reg_rd, reg_rvalid, chip_reset, loopback, speed_100, full_duplex;
   logic autoneg_en, autoneg_restart, power_down, isolate, col_test;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd_v;
   logic [4:0] addrs [4] = '{5'h01, 5'h0F, 5'h10, 5'h1F};
   int n_fail = 0, total_checks = 0;
   wire [6:0] modes = {loopback, isolate, col_test, full_duplex, speed_100, autoneg_en, power_down};
   initial forever #2 clk = ~clk;
   pbc_mgr u_mgr (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   pbc_basic_control #(.RESET_CYCLES(2)) uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .strap_autoneg_and_speed(strap), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chip_reset(chip_reset),
      .loopback(loopback), .speed_100(speed_100), .full_duplex(full_duplex), .autoneg_en(autoneg_en),
      .autoneg_restart(autoneg_restart), .power_down(power_down), .isolate(isolate), .col_test(col_test));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rchk(input logic [4:0] a, input logic [15:0] e);
      u_mgr.rd(a, rd_v);
      chk("rdata", rd_v, e);
      chk("rvalid", reg_rvalid, 16'h0001);
   endtask
   // Bounded poll: a stuck reset bit must not hang the run
   task automatic poll;
      repeat (20)
      begin
         u_mgr.rd(5'h00, rd_v);
         if (rd_v[15] === 1'b0)
            return;
      end
      chk("poll", rd_v, 16'h0000);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #20000;
      n_fail++;
      finish_test();
   end
   initial
   begin
      repeat (6) @(negedge clk);
      rst_n = 1;
      repeat (3) @(negedge clk);
      rchk(5'h00, 16'h3100);
      chk("modes", modes, 7'b0000010);
      $display("test reset values done");
      u_mgr.wr(5'h00, 16'h45FF);
      rchk(5'h00, 16'h4580);
      chk("modes", modes, 7'b1111000);
      u_mgr.wr(5'h00, 16'h2100);
      rchk(5'h00, 16'h2100);
      chk("modes", modes, 7'b0001100);
      u_mgr.wr(5'h00, 16'h3300);
      chk("restart", autoneg_restart, 16'h0001);
      rchk(5'h00, 16'h3100);
      chk("modes", modes, 7'b0000010);
      $display("test control bits done");
      @(negedge clk);
      clk_en = 0;
      u_mgr.wr(5'h00, 16'h4800);
      clk_en = 1;
      rchk(5'h00, 16'h3100);
      chk("modes", modes, 7'b0000010);
      $display("test clock enable done");
      foreach (addrs[i])
      begin
         u_mgr.wr(addrs[i], 16'hA5A0 | 16'(addrs[i]));
         rchk(addrs[i], 16'hA5A0 | 16'(addrs[i]));
      end
      $display("test register space done");
      strap = 0;
      u_mgr.wr(5'h00, 16'h8000);
      @(negedge clk);
      chk("chip_reset", chip_reset, 16'h0001);
      poll();
      rchk(5'h00, 16'h0100);
      rchk(5'h1F, 16'h0000);
      $display("test software reset done");
      u_mgr.wr(5'h00, 16'h0800);
      rchk(5'h00, 16'h0800);
      chk("modes", modes, 7'b0000001);
      strap = 1;
      u_mgr.wr(5'h00, 16'h8000);
      @(negedge clk);
      chk("chip_reset", chip_reset, 16'h0000);
      poll();
      rchk(5'h00, 16'h0000);
      u_mgr.wr(5'h00, 16'h8000);
      poll();
      rchk(5'h00, 16'h3100);
      $display("test power-down exit done");
      strap = 0;
      rst_n = 0;
      repeat (2) @(negedge clk);
      rst_n = 1;
      repeat (3) @(negedge clk);
      rchk(5'h00, 16'h0100);
      chk("modes", modes, 7'b0001000);
      $display("test hardware reset done");
      finish_test();
   end
endmodule
